// ---- hw/sio_irq_ctrl.sv ----
// Purpose: Interrupt identification and FIFO control of a serial port.
// Assumes: Character-time ticks and FIFO levels come from the datapath.
// Notes: FIFOs themselves live in the datapath; this block steers them.
`timescale 1ns/1ps
`default_nettype none
module sio_irq_ctrl
  import sio_irq_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [29:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic line_err_i,
  input wire logic status_read_i,
  input wire logic rx_push_i,
  input wire logic rx_pop_i,
  input wire logic [4:0] rx_level_i,
  input wire logic tx_push_i,
  input wire logic [4:0] tx_level_i,
  input wire logic tx_shift_busy_i,
  input wire logic char_tick_i,
  input wire logic stop_tick_i,
  input wire logic cts_change_i,
  input wire logic modem_read_i,
  output logic rx_fifo_clear_o,
  output logic tx_fifo_clear_o,
  output logic fifo_mode_o,
  output logic fifo_enable_o,
  output logic data_ready_o,
  output logic tx_holding_empty_o,
  output logic tx_all_empty_o,
  output logic irq_o
);
  logic [7:0] fifo_control_q;
  logic [3:0] int_enable_q;
  logic line_q, modem_q, hold_q, timeout_q, ready_q;
  logic [2:0] idle_chars_q;
  logic [1:0] burst_q;
  logic delay_q, first_q, ack_q;
  logic [31:0] dat_q;

  // Bus decode; word index equals printed offset
  wire req = cyc_i & stb_i & ~ack_q;
  wire hit_ident = adr_i == IDENT_FIFO_CTRL_IDX[29:0];
  wire hit_ie = adr_i == INT_ENABLE_IDX[29:0];
  wire hit_stat = adr_i == STATUS_IDX[29:0];
  wire wr_fc = req & we_i & sel_i[0] & hit_ident;
  wire wr_ie = req & we_i & sel_i[0] & hit_ie;
  wire rd_ident = req & ~we_i & hit_ident;

  // Trigger level decode
  function automatic logic [4:0] trig_level(input logic [1:0] sel);
    unique case (sel)
      2'h3: trig_level = TRIG_14;
      2'h2: trig_level = TRIG_8;
      2'h1: trig_level = TRIG_4;
      2'h0: trig_level = TRIG_0;
    endcase
  endfunction : trig_level

  wire fifo_on = fifo_control_q[FIFO_EN_BIT];
  wire mode_fifo = fifo_control_q[MODE_BIT];
  // Zero trigger means any byte counts as data present
  wire rx_at_trig = (rx_level_i >= trig_level(fifo_control_q[7:6])) &&
                    (rx_level_i != 5'h00);
  wire rx_data_src = fifo_on ? rx_at_trig : ready_q;
  wire tx_empty = tx_level_i == 5'h00;

  // Gated sources; disabled ones stay invisible (polling)
  wire p_line = line_q & int_enable_q[EN_LINE];
  wire p_data = rx_data_src & int_enable_q[EN_DATA];
  wire p_tout = timeout_q & mode_fifo & int_enable_q[EN_DATA];
  wire p_hold = hold_q & int_enable_q[EN_HOLD];
  wire p_modem = modem_q & int_enable_q[EN_MODEM];
  wire any_pend = p_line | p_data | p_tout | p_hold | p_modem;

  // Priority encoder of bits 3..1
  logic [2:0] code;
  always_comb begin
    if (p_line) code = CODE_LINE;
    else if (p_data) code = CODE_DATA;
    else if (p_tout) code = CODE_TIMEOUT;
    else if (p_hold) code = CODE_HOLD;
    else code = CODE_MODEM;
  end
  wire [7:0] ident = {{2{fifo_on}}, 2'b00, any_pend ? code : 3'h0, ~any_pend};
  wire hold_reported = p_hold & ~p_line & ~p_data & ~p_tout;

  // Control registers; clear bits self-clear after one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fifo_control_q <= FIFO_CTRL_RESET;
      int_enable_q <= INT_ENABLE_RESET;
    end else begin
      fifo_control_q[RX_CLR_BIT] <= 1'b0;
      fifo_control_q[TX_CLR_BIT] <= 1'b0;
      if (wr_fc) fifo_control_q <= dat_i[7:0] & 8'hCF;
      if (wr_ie) int_enable_q <= dat_i[3:0];
    end
  end

  // Sticky sources; set wins over clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      line_q <= 1'b0;
      modem_q <= 1'b0;
      ready_q <= 1'b0;
    end else begin
      line_q <= line_err_i | (line_q & ~status_read_i);
      modem_q <= cts_change_i | (modem_q & ~modem_read_i);
      // Only the pop of the last character or a receive clear empties the FIFO
      ready_q <= rx_push_i | (ready_q & ~(rx_pop_i & (rx_level_i <= 5'h01)) & ~rx_fifo_clear_o);
    end
  end

  // Timeout counter in character ticks
  always_ff @(posedge clk_i) begin
    if (rst_i || rx_fifo_clear_o) begin
      idle_chars_q <= 3'h0;
      timeout_q <= 1'b0;
    end else if (rx_push_i || rx_pop_i) begin
      idle_chars_q <= 3'h0;
      timeout_q <= 1'b0;
    end else if (rx_level_i == 5'h00) begin
      idle_chars_q <= 3'h0;
    end else if (char_tick_i && idle_chars_q != TIMEOUT_CHARS) begin
      idle_chars_q <= idle_chars_q + 3'h1;
      if (idle_chars_q + 3'h1 == TIMEOUT_CHARS) timeout_q <= 1'b1;
    end
  end

  // Holding-empty request with short-burst delay
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_q <= 1'b0;
      burst_q <= 2'h0;
      delay_q <= 1'b0;
      first_q <= 1'b1;
    end else begin
      if (wr_fc) first_q <= 1'b1;
      if (tx_push_i && burst_q != SHORT_BURST) burst_q <= burst_q + 2'h1;
      if (tx_empty && !hold_q && !delay_q && burst_q != 2'h0) begin
        if (burst_q < SHORT_BURST && !first_q) delay_q <= 1'b1;
        else begin
          hold_q <= 1'b1;
          first_q <= 1'b0;
        end
        burst_q <= 2'h0;
      end else if (delay_q && stop_tick_i) begin
        delay_q <= 1'b0; // Held a character plus stop time
        hold_q <= 1'b1;
      end else if (tx_push_i || (rd_ident && hold_reported)) begin
        hold_q <= 1'b0;
      end
    end
  end

  // Read data and single-wait ack
  wire [31:0] rd_mux = hit_ident ? {24'h000000, ident} :
                       hit_ie ? {28'h0000000, int_enable_q} :
                       hit_stat ? {25'h0, tx_all_empty_o, tx_holding_empty_o, 4'h0, data_ready_o} :
                       32'h00000000;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
    end else begin
      ack_q <= req;
      if (req) dat_q <= rd_mux;
    end
  end

  assign ack_o = ack_q;
  assign dat_o = dat_q;
  assign rx_fifo_clear_o = fifo_control_q[RX_CLR_BIT];
  assign tx_fifo_clear_o = fifo_control_q[TX_CLR_BIT];
  assign fifo_mode_o = mode_fifo;
  assign fifo_enable_o = fifo_on;
  assign data_ready_o = ready_q;
  assign tx_holding_empty_o = tx_empty;
  assign tx_all_empty_o = tx_empty & ~tx_shift_busy_i;
  assign irq_o = any_pend;

  // Identification byte checks; these watch the decoded byte software sees
  // Top bits follow the enable bit
  a_top_bits: assert property (@(posedge clk_i) disable iff (rst_i)
    ident[7:6] == {2{fifo_on}}) else $error("top bits wrong");

  // Top bits clear while FIFOs are off
  a_top_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    !fifo_on |-> ident[7:6] == 2'b00) else $error("top bits set with fifos off");

  // Any enabled line or modem source forces the pending bit low
  a_pend_bit: assert property (@(posedge clk_i) disable iff (rst_i)
    (line_q && int_enable_q[EN_LINE]) || (modem_q && int_enable_q[EN_MODEM]) |-> !ident[0])
    else $error("pending bit mismatch");

  // Nothing pending reads as the idle code
  a_idle_code: assert property (@(posedge clk_i) disable iff (rst_i)
    !any_pend |-> ident[3:0] == 4'h1) else $error("idle code wrong");

  // Line status beats every other source
  a_line_first: assert property (@(posedge clk_i) disable iff (rst_i)
    p_line |-> ident[3:1] == CODE_LINE) else $error("line priority lost");

  // Data code when line status is quiet
  a_data_code: assert property (@(posedge clk_i) disable iff (rst_i)
    p_data && !p_line |-> ident[3:1] == CODE_DATA) else $error("data code wrong");

  // Timeout code below data
  a_tout_code: assert property (@(posedge clk_i) disable iff (rst_i)
    p_tout && !p_line && !p_data |-> ident[3:1] == CODE_TIMEOUT) else $error("timeout code wrong");

  // Holding-empty code when it is the reported source
  a_hold_code: assert property (@(posedge clk_i) disable iff (rst_i)
    hold_reported |-> ident[3:1] == CODE_HOLD) else $error("hold code wrong");

  // Modem code only when nothing higher waits
  a_modem_code: assert property (@(posedge clk_i) disable iff (rst_i)
    p_modem && !(p_line || p_data || p_tout || p_hold) |-> ident[3:1] == CODE_MODEM)
    else $error("modem code wrong");

  // Timeout bit implies bit 2 and FIFO mode
  a_tout_bit2: assert property (@(posedge clk_i) disable iff (rst_i)
    ident[3] |-> ident[2] && mode_fifo) else $error("timeout code bad");

  // Character mode never shows the timeout bit
  a_char_mode: assert property (@(posedge clk_i) disable iff (rst_i)
    !mode_fifo |-> !ident[3]) else $error("timeout bit in character mode");

  // Control strobes last exactly one cycle
  a_clr_self: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_fifo_clear_o |=> !rx_fifo_clear_o) else $error("rx clear stuck");

  a_txclr_self: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_fifo_clear_o |=> !tx_fifo_clear_o) else $error("tx clear stuck");

  // A written clear bit reaches the receive FIFO
  a_clr_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_fc && dat_i[RX_CLR_BIT] |=> rx_fifo_clear_o) else $error("rx clear not issued");

  // Receive clear also drops a pending timeout
  a_clr_tout: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_fifo_clear_o |=> !timeout_q) else $error("timeout survived clear");

  // Enable and mode bits land as written
  a_fcr_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_fc |=> fifo_on == $past(dat_i[FIFO_EN_BIT]) && mode_fifo == $past(dat_i[MODE_BIT]))
    else $error("fifo control not written");

  // Interrupt enables land as written
  a_ie_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_ie |=> int_enable_q == $past(dat_i[3:0])) else $error("enables not written");

  // Write to holding register drops the request
  a_hold_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_push_i && hold_q |=> !hold_q) else $error("hold not cleared");

  // Identification read drops a reported holding request
  a_hold_ident: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_ident && hold_reported && !delay_q |=> !hold_q) else $error("ident read kept hold");

  // Error and modem events are sticky until read
  a_line_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    line_err_i |=> line_q) else $error("line error lost");

  a_line_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    status_read_i && !line_err_i |=> !line_q) else $error("line status not cleared");

  a_modem_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    cts_change_i |=> modem_q) else $error("modem change lost");

  a_modem_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    modem_read_i && !cts_change_i |=> !modem_q) else $error("modem status not cleared");

  // Data ready follows entries and the final pop
  a_ready_set: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_push_i |=> data_ready_o) else $error("ready not set");

  a_ready_empty: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_pop_i && rx_level_i == 5'h01 && !rx_push_i |=> !data_ready_o) else $error("ready not cleared");

  a_ready_kept: assert property (@(posedge clk_i) disable iff (rst_i)
    data_ready_o && rx_level_i > 5'h01 && !rx_fifo_clear_o |=> data_ready_o) else $error("ready lost early");

  // Full trigger level raises the request
  a_trig_data: assert property (@(posedge clk_i) disable iff (rst_i)
    fifo_on && int_enable_q[EN_DATA] && fifo_control_q[7:6] == 2'h3 && rx_level_i >= TRIG_14 |-> irq_o)
    else $error("trigger level missed");

  // Below trigger and nothing else: no request
  a_below_trig: assert property (@(posedge clk_i) disable iff (rst_i)
    fifo_on && !p_line && !p_tout && !p_hold && !p_modem &&
    rx_level_i < trig_level(fifo_control_q[7:6]) |-> !irq_o) else $error("request below trigger");

  // Pops clear a timeout; pushes restart the timer
  a_tout_pop: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_pop_i |=> !timeout_q) else $error("timeout survived read");

  a_tout_push: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_push_i |=> idle_chars_q == 3'h0) else $error("timer not restarted");

  // Polling: a disabled side never requests
  a_poll_rx: assert property (@(posedge clk_i) disable iff (rst_i)
    fifo_on && !int_enable_q[EN_DATA] && !p_line && !p_hold && !p_modem |-> !irq_o)
    else $error("receive polling raised irq");

  a_poll_tx: assert property (@(posedge clk_i) disable iff (rst_i)
    !int_enable_q[EN_HOLD] && !p_line && !p_data && !p_tout && !p_modem |-> !irq_o)
    else $error("transmit polling raised irq");

  // Short bursts wait for the stop tick, then report
  a_delay_wait: assert property (@(posedge clk_i) disable iff (rst_i)
    delay_q && !stop_tick_i |=> delay_q) else $error("delay ended early");

  a_delay_end: assert property (@(posedge clk_i) disable iff (rst_i)
    delay_q && stop_tick_i |=> hold_q && !delay_q) else $error("delayed hold lost");

  // First empty after a control write is immediate
  a_first_now: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_empty && !hold_q && !delay_q && burst_q != 2'h0 && first_q |=> hold_q) else $error("first hold delayed");

  // Transmit empty flags stay consistent
  a_all_empty: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_all_empty_o |-> tx_holding_empty_o) else $error("all empty without fifo empty");

  a_shift_busy: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_shift_busy_i |-> !tx_all_empty_o) else $error("all empty while shifting");

  // Masked sources stay hidden
  a_gate_off: assert property (@(posedge clk_i) disable iff (rst_i)
    int_enable_q == 4'h0 |-> !irq_o) else $error("disabled irq shown");

  // Reset values; checked through reset itself
  a_ident_reset: assert property (@(posedge clk_i)
    rst_i |=> ident == IDENT_RESET) else $error("ident reset wrong");

  a_fc_reset: assert property (@(posedge clk_i)
    rst_i |=> fifo_control_q == FIFO_CTRL_RESET && int_enable_q == INT_ENABLE_RESET)
    else $error("control reset wrong");

  // Bus answers after one wait and for one cycle only
  a_ack_reply: assert property (@(posedge clk_i) disable iff (rst_i)
    cyc_i && stb_i && !ack_o |=> ack_o) else $error("request not acknowledged");

  a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o) else $error("ack held too long");

  // Main scenarios worth seeing at least once
  c_timeout: cover property (@(posedge clk_i) p_tout);
  c_hold_delay: cover property (@(posedge clk_i) delay_q ##[1:50] hold_q);
  c_line_over_data: cover property (@(posedge clk_i) p_line && p_data);
  c_trig_data: cover property (@(posedge clk_i) p_data && fifo_on);
  c_hold_first: cover property (@(posedge clk_i) hold_q && first_q == 1'b0);
endmodule : sio_irq_ctrl
`default_nettype wire

// ---- hw/sio_irq_pkg.sv ----
// Summary of operation
// - Top identification bits mirror FIFO enable
// - Bit zero low while enabled interrupt pending
// - Priority: line, data, timeout, holding, modem
// - Timeout bit only in FIFO mode, implies bit2
// - Line status code 011, cleared by status read
// - Data code 010, cleared by read or drain
// - Timeout code 110, cleared by buffer read
// - Holding empty code 001, cleared by ident read/write
// - Modem code 000, cleared by modem status read
// - Trigger bits select 14, 8, 4, 0 bytes
// - Bit3 selects FIFO mode, bit0 enables FIFOs
// - Bit2 clears transmit FIFO, self-clearing
// - Bit1 clears receive FIFO, self-clearing
// - Data request follows fill versus trigger level
// - Data ready set on entry, cleared when empty
// - Timeout after four idle character times
// - Reads and receptions restart timeout timer
// - Holding empty request when transmit FIFO empties
// - Delay empty report after short bursts
// - First transmit interrupt after FIFO control write immediate
// - Bit6 all empty, bit5 FIFO only
// - Disabled enables give polling, FIFOs still store
// - Disabled sources never show pending
// - Enable bits gate modem, line, holding, data
//
// Purpose: Constants for the serial port interrupt/FIFO control block.
// Assumes: Wishbone classic slave, 32-bit data, byte registers in low bits.
// Notes: Printed offsets are not multiples of four, so index*4 is the address.
package sio_irq_pkg;
  localparam logic [31:0] IDENT_FIFO_CTRL_IDX = 32'h0F000822;
  localparam logic [31:0] INT_ENABLE_IDX = 32'h0F000821;
  localparam logic [31:0] STATUS_IDX = 32'h0F000825;
  localparam logic [7:0] IDENT_RESET = 8'h01;
  localparam logic [7:0] FIFO_CTRL_RESET = 8'h00;
  localparam logic [3:0] INT_ENABLE_RESET = 4'h0;
  localparam int unsigned FIFO_EN_BIT = 0;
  localparam int unsigned RX_CLR_BIT = 1;
  localparam int unsigned TX_CLR_BIT = 2;
  localparam int unsigned MODE_BIT = 3;
  localparam int unsigned EN_MODEM = 3;
  localparam int unsigned EN_LINE = 2;
  localparam int unsigned EN_HOLD = 1;
  localparam int unsigned EN_DATA = 0;
  localparam logic [2:0] CODE_LINE = 3'h3;
  localparam logic [2:0] CODE_DATA = 3'h2;
  localparam logic [2:0] CODE_TIMEOUT = 3'h6;
  localparam logic [2:0] CODE_HOLD = 3'h1;
  localparam logic [2:0] CODE_MODEM = 3'h0;
  localparam logic [4:0] TRIG_14 = 5'h0E;
  localparam logic [4:0] TRIG_8 = 5'h08;
  localparam logic [4:0] TRIG_4 = 5'h04;
  localparam logic [4:0] TRIG_0 = 5'h00;
  localparam logic [2:0] TIMEOUT_CHARS = 3'h4;
  localparam logic [1:0] SHORT_BURST = 2'h2;
endpackage : sio_irq_pkg

// ---- verification/sio_peer_model.sv ----
// Purpose: Far-side stand-in for the datapath and the remote serial peer
// Assumes: At most one receive push or pop per cycle
// Notes: Fill levels are behavioural counters; no character data is stored
`timescale 1ns/1ps
`default_nettype none
module sio_peer_model (
  input wire logic clk_i,
  input wire logic rx_pop_i,
  input wire logic tx_push_i,
  output logic rx_push_o,
  output logic [4:0] rx_level_o,
  output logic char_tick_o,
  output logic [4:0] tx_level_o,
  output logic stop_tick_o
);
  logic tx_sent_q;
  initial begin
    {rx_push_o, char_tick_o, stop_tick_o, tx_sent_q} = 4'h0;
    rx_level_o = 5'h00;
    tx_level_o = 5'h00;
  end
  // Fill counters track pushes and pops; a sent burst empties transmit side
  always @(posedge clk_i) begin
    rx_level_o <= rx_level_o + 5'(rx_push_o) - 5'(rx_pop_i);
    tx_level_o <= tx_sent_q ? 5'h00 : tx_level_o + 5'(tx_push_i);
  end
  // Characters arrive with an idle cycle between them
  task automatic send_chars(input int n);
    repeat (n) begin
      @(posedge clk_i) rx_push_o <= 1'b1;
      @(posedge clk_i) rx_push_o <= 1'b0;
    end
  endtask : send_chars
  task automatic char_times(input int n);
    repeat (n) begin
      @(posedge clk_i) char_tick_o <= 1'b1;
      @(posedge clk_i) char_tick_o <= 1'b0;
    end
  endtask : char_times
  // Empty first, then the character-plus-stop tick, so a delay can end
  task automatic tx_sent();
    @(posedge clk_i) tx_sent_q <= 1'b1;
    @(posedge clk_i) tx_sent_q <= 1'b0;
    @(posedge clk_i) stop_tick_o <= 1'b1;
    @(posedge clk_i) stop_tick_o <= 1'b0;
  endtask : tx_sent
endmodule : sio_peer_model
`default_nettype wire

// ---- verification/tb_uart_interrupt_id_and_fifo_control.sv ----
// Purpose: Self-checking bench for the interrupt identification block
// Assumes: Wishbone classic, one wait state; registers in the low byte
// Notes: Shift-register busy is tied low, so all-empty follows the FIFO
`timescale 1ns/1ps
`default_nettype none
module tb_uart_interrupt_id_and_fifo_control;
  import sio_irq_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack_o, irq_o;
  logic rxc_seen = 1'b0, txc_seen = 1'b0, rx_push, char_tick, stop_tick, rx_clr, tx_clr, mode, fen, ready, hold, all;
  logic [29:0] adr = 30'h0;
  logic [31:0] dat = 32'h0, dat_o;
  logic [5:0] ev = 6'h00;
  logic [4:0] rx_level, tx_level;
  logic [7:0] q;
  int fails = 0, compares = 0;
  localparam logic [29:0] IDF = IDENT_FIFO_CTRL_IDX[29:0];
  localparam logic [29:0] IEN = INT_ENABLE_IDX[29:0];
  always #4 clk_i = ~clk_i;
  sio_irq_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(4'hF), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .line_err_i(ev[0]), .status_read_i(ev[1]),
    .rx_push_i(rx_push), .rx_pop_i(ev[2]), .rx_level_i(rx_level), .tx_push_i(ev[3]), .tx_level_i(tx_level),
    .tx_shift_busy_i(1'b0), .char_tick_i(char_tick), .stop_tick_i(stop_tick), .cts_change_i(ev[4]),
    .modem_read_i(ev[5]), .rx_fifo_clear_o(rx_clr), .tx_fifo_clear_o(tx_clr), .fifo_mode_o(mode),
    .fifo_enable_o(fen), .data_ready_o(ready), .tx_holding_empty_o(hold), .tx_all_empty_o(all), .irq_o(irq_o));
  sio_peer_model peer (.clk_i(clk_i), .rx_pop_i(ev[2]), .tx_push_i(ev[3]), .rx_push_o(rx_push),
    .rx_level_o(rx_level), .char_tick_o(char_tick), .tx_level_o(tx_level), .stop_tick_o(stop_tick));
  // Clear strobes last one cycle, so catch them as they pass
  always @(posedge clk_i) begin
    if (rx_clr === 1'b1) rxc_seen <= 1'b1;
    if (tx_clr === 1'b1) txc_seen <= 1'b1;
  end
  // Expected identification byte with FIFOs enabled
  function automatic logic [7:0] id(input logic [2:0] c);
    return {4'hC, c, 1'b0};
  endfunction : id
  task automatic wb(input logic w, input logic [29:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i) {cyc, stb, we, adr, dat} <= {2'h3, w, a, 24'h0, d};
    do begin
      @(negedge clk_i) n++;
    end while (ack_o !== 1'b1 && n < 50);
    @(posedge clk_i) q = dat_o[7:0];
    {cyc, stb, we} <= 3'h0;
    if (n >= 50) fails++;
  endtask : wb
  task automatic pulse(input int b);
    @(posedge clk_i) ev <= 6'h01 << b;
    @(posedge clk_i) ev <= 6'h00;
    @(posedge clk_i);
  endtask : pulse
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wrap_up();
    $display("Comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up
  // Hang guard, well beyond the fewer than two hundred cycles the tests need
  initial begin
    #200000;
    fails++;
    wrap_up();
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, IDF, 8'h00); chk("ident reset", q, IDENT_RESET);
    chk("irq idle", {7'h0, irq_o}, 8'h00);
    wb(1'b0, 30'h0, 8'h00); chk("unmapped", q, 8'h00);
    $display("Test reset done");
    wb(1'b1, IDF, 8'hCF); wb(1'b0, IDF, 8'h00);
    chk("clears seen", {6'h0, rxc_seen, txc_seen}, 8'h03);
    chk("clears dropped", {6'h0, rx_clr, tx_clr}, 8'h00);
    chk("mode enable", {6'h0, mode, fen}, 8'h03);
    chk("ident fifo", q, 8'hC1);
    $display("Test fifo control done");
    wb(1'b1, IEN, 8'h0D); pulse(4); pulse(0);
    wb(1'b0, IDF, 8'h00); chk("line first", q, id(CODE_LINE));
    chk("irq pending", {7'h0, irq_o}, 8'h01);
    pulse(1); wb(1'b0, IDF, 8'h00); chk("modem", q, id(CODE_MODEM));
    pulse(5); wb(1'b0, IDF, 8'h00); chk("none", q, 8'hC1);
    $display("Test line modem done");
    peer.send_chars(14); wb(1'b0, IDF, 8'h00); chk("data", q, id(CODE_DATA));
    chk("ready", {7'h0, ready}, 8'h01);
    pulse(2); wb(1'b0, IDF, 8'h00); chk("below trig", q, 8'hC1);
    chk("ready kept", {7'h0, ready}, 8'h01);
    peer.char_times(4); wb(1'b0, IDF, 8'h00); chk("timeout", q, id(CODE_TIMEOUT));
    pulse(2); wb(1'b0, IDF, 8'h00); chk("timeout clr", q, 8'hC1);
    $display("Test receive done");
    pulse(3); chk("fifo busy", {6'h0, hold, all}, 8'h00);
    wb(1'b1, IEN, 8'h0F); peer.tx_sent();
    wb(1'b0, IDF, 8'h00); chk("hold", q, id(CODE_HOLD));
    wb(1'b0, IDF, 8'h00); chk("hold clr", q, 8'hC1);
    chk("tx empty", {6'h0, hold, all}, 8'h03);
    pulse(3); peer.tx_sent(); wb(1'b0, IEN, 8'h00); chk("enables", q, 8'h0F);
    chk("delayed hold", {7'h0, irq_o}, 8'h01);
    pulse(3); chk("hold by write", {7'h0, irq_o}, 8'h00);
    $display("Test transmit done");
    wb(1'b1, IEN, 8'h00); pulse(0);
    wb(1'b0, IDF, 8'h00); chk("masked", q, 8'hC1);
    chk("irq masked", {7'h0, irq_o}, 8'h00);
    $display("Test masking done");
    wrap_up();
  end
endmodule : tb_uart_interrupt_id_and_fifo_control
`default_nettype wire
